// ===== core/aewr_pkg.sv
package aewr_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_FRAME   = 8'h00;
	localparam logic [7:0] OFS_FADDR   = 8'h04;
	localparam logic [7:0] OFS_IRQ_ST  = 8'h08;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h0c;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
	localparam logic [7:0] OFS_CTRL    = 8'h14;

	// frame word field positions
	localparam int FB_WB1_V = 0;
	localparam int FB_WB1_M = 1;
	localparam int FB_WB2_V = 2;
	localparam int FB_WB2_M = 3;
	localparam int FB_WB3_V = 4;
	localparam int FB_WB3_M = 5;
	localparam int FB_RW    = 6;
	localparam int FB_TT_LO = 8;
	localparam int FB_TM_LO = 10;
	localparam int FB_VALID = 16;

	// control word: bit 0 releases the frame
	localparam int CB_RELEASE = 0;

	// interrupt event bits
	localparam int EV_CAPTURE = 0;
	localparam int EV_OVERRUN = 1;
	localparam int EV_NUM     = 2;

	// transfer type / modifier encodings
	localparam logic [1:0] TT_NORMAL    = 2'h0;
	localparam logic [1:0] TT_LINE_MOVE = 2'h1;
	localparam logic [2:0] TM_PUSH      = 3'h0;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	typedef enum logic [2:0] {
		AEWR_READ,
		AEWR_PUSH,
		AEWR_WRITE,
		AEWR_LM_WRITE,
		AEWR_PAGE_FAULT
	} aewr_kind_e;
endpackage

// ===== core/aewr_events.sv
`timescale 1ns/1ps
module aewr_events #(
	parameter int N = 2
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic [N-1:0] event_set,
	input  wire logic [N-1:0] clear_bits,
	input  wire logic         clear_we,
	input  wire logic [N-1:0] enable_bits,
	input  wire logic         enable_we,
	output logic      [N-1:0] status,
	output logic      [N-1:0] enable,
	output logic              irq
);
	logic [N-1:0] status_d;
	logic [N-1:0] status_q;
	logic [N-1:0] enable_d;
	logic [N-1:0] enable_q;

	// a set in the clearing cycle wins
	always_comb begin
		status_d = status_q;
		enable_d = enable_q;
		if (clear_we) begin
			status_d = status_d & ~clear_bits;
		end
		status_d = status_d | event_set;
		if (enable_we) begin
			enable_d = enable_bits;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			status_q <= '0;
			enable_q <= '0;
		end else begin
			status_q <= status_d;
			enable_q <= enable_d;
		end
	end

	assign status = status_q;
	assign enable = enable_q;
	assign irq    = |(status_q & enable_q);
endmodule

// ===== core/aewr_core.sv
`timescale 1ns/1ps
// Behaviour
// - read access error reports first and second write-back slots not valid.
// - data memory stage stalls on a read until data reaches execution.
// - read error may report a pending third-slot write-back.
// - cache push fault always reports first-slot valid bit clear.
// - push fault loads physical fault address; all other faults logical.
// - no posted write while a line-move sits in the second slot.
// - line-move in second slot only after its read hit the cache.
// - push fault encodes transfer type 00 and transfer modifier 000.
module aewr_core (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq,
	input  wire logic        rd_start,
	input  wire logic        rd_data_done,
	output logic             dm_stall,
	input  wire logic        slot2_load,
	input  wire logic        slot2_line_move,
	input  wire logic        slot2_read_hit,
	output logic             slot2_ready,
	input  wire logic        slot2_drain,
	input  wire logic        exec_post_req,
	output logic             exec_post_ready,
	input  wire logic        slot3_drain,
	input  wire logic        fault_valid,
	input  wire logic [2:0]  fault_kind,
	input  wire logic [2:0]  fault_tm,
	input  wire logic [31:0] fault_logical_addr,
	input  wire logic [31:0] fault_physical_addr,
	output logic             frame_valid
);
	// pending write-back slots
	logic        stall_d;
	logic        stall_q;
	logic        s2v_d;
	logic        s2v_q;
	logic        s2m_d;
	logic        s2m_q;
	logic        s3v_d;
	logic        s3v_q;
	// captured frame
	logic [31:0] frame_d;
	logic [31:0] frame_q;
	logic [31:0] fa_d;
	logic [31:0] fa_q;
	logic        release_we;
	logic        take_fault;
	logic        wb_hit;
	logic        bus_wr;
	logic        ack_d;
	logic        ack_q;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic [aewr_pkg::EV_NUM-1:0] ev_set;
	logic [aewr_pkg::EV_NUM-1:0] ev_status;
	logic [aewr_pkg::EV_NUM-1:0] ev_enable;
	logic        clr_we;
	logic        en_we;

	assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
	assign wb_hit  = wb_cyc_i && wb_stb_i && !ack_q;
	assign release_we = bus_wr && (wb_adr_i == aewr_pkg::OFS_CTRL) && wb_sel_i[0]
		&& wb_dat_i[aewr_pkg::CB_RELEASE];
	assign take_fault = fault_valid && !frame_q[aewr_pkg::FB_VALID];
	assign clr_we  = bus_wr && (wb_adr_i == aewr_pkg::OFS_IRQ_CLR) && wb_sel_i[0];
	assign en_we   = bus_wr && (wb_adr_i == aewr_pkg::OFS_IRQ_EN) && wb_sel_i[0];

	// a line-move read that missed waits until it hits
	// a line-move also waits for the third slot to empty
	assign slot2_ready     = !s2v_q && (!slot2_line_move || (slot2_read_hit && !s3v_q));
	// posting waits while a line-move occupies the second slot
	assign exec_post_ready = !s3v_q && !(s2v_q && s2m_q) && !(slot2_load && slot2_ready && slot2_line_move);
	assign dm_stall        = stall_q;
	assign frame_valid     = frame_q[aewr_pkg::FB_VALID];

	always_comb begin
		stall_d = stall_q;
		if (rd_start) begin
			stall_d = 1'b1;
		end
		if (rd_data_done) begin
			stall_d = 1'b0;
		end
	end

	always_comb begin
		s2v_d = s2v_q;
		s2m_d = s2m_q;
		s3v_d = s3v_q;
		if (slot2_drain) begin
			s2v_d = 1'b0;
		end
		if (slot3_drain) begin
			s3v_d = 1'b0;
		end
		if (slot2_load && slot2_ready) begin
			s2v_d = 1'b1;
			s2m_d = slot2_line_move;
		end
		if (exec_post_req && exec_post_ready) begin
			s3v_d = 1'b1;
		end
		// pending writes move into the frame for the handler, except the second slot on a read fault
		if (take_fault) begin
			s2v_d = 1'b0;
			s2m_d = 1'b0;
			s3v_d = 1'b0;
		end
	end

	always_comb begin
		frame_d = frame_q;
		fa_d    = fa_q;
		if (release_we) begin
			frame_d = aewr_pkg::RESET_WORD;
		end
		if (take_fault) begin
			frame_d = aewr_pkg::RESET_WORD;
			frame_d[aewr_pkg::FB_VALID] = 1'b1;
			frame_d[aewr_pkg::FB_WB3_V] = s3v_q;
			frame_d[aewr_pkg::FB_WB2_V] = s2v_q;
			frame_d[aewr_pkg::FB_WB2_M] = s2v_q && s2m_q;
			frame_d[aewr_pkg::FB_TM_LO +: 3] = fault_tm;
			fa_d = fault_logical_addr;
			case (fault_kind)
				aewr_pkg::AEWR_READ: begin
					frame_d[aewr_pkg::FB_RW]   = 1'b1;
					frame_d[aewr_pkg::FB_WB2_V] = 1'b0;
					frame_d[aewr_pkg::FB_WB2_M] = 1'b0;
					frame_d[aewr_pkg::FB_WB3_V] = s3v_q;
				end
				aewr_pkg::AEWR_PUSH: begin
					frame_d[aewr_pkg::FB_WB1_V] = 1'b0;
					frame_d[aewr_pkg::FB_TT_LO +: 2] = aewr_pkg::TT_NORMAL;
					frame_d[aewr_pkg::FB_TM_LO +: 3] = aewr_pkg::TM_PUSH;
					fa_d = fault_physical_addr;
				end
				aewr_pkg::AEWR_WRITE: begin
					frame_d[aewr_pkg::FB_WB1_V] = 1'b1;
				end
				aewr_pkg::AEWR_LM_WRITE: begin
					frame_d[aewr_pkg::FB_WB1_V] = 1'b1;
					frame_d[aewr_pkg::FB_WB1_M] = 1'b1;
					frame_d[aewr_pkg::FB_TT_LO +: 2] = aewr_pkg::TT_LINE_MOVE;
				end
				aewr_pkg::AEWR_PAGE_FAULT: begin
					frame_d[aewr_pkg::FB_WB1_V] = 1'b0;
				end
				default: begin
					frame_d[aewr_pkg::FB_WB1_V] = 1'b0;
				end
			endcase
		end
	end

	always_comb begin
		ev_set = '0;
		ev_set[aewr_pkg::EV_CAPTURE] = take_fault;
		ev_set[aewr_pkg::EV_OVERRUN] = fault_valid && frame_q[aewr_pkg::FB_VALID];
	end

	always_comb begin
		ack_d   = wb_hit;
		rdata_d = aewr_pkg::RESET_WORD;
		if (wb_hit && !wb_we_i) begin
			case (wb_adr_i)
				aewr_pkg::OFS_FRAME:  rdata_d = frame_q;
				aewr_pkg::OFS_FADDR:  rdata_d = fa_q;
				aewr_pkg::OFS_IRQ_ST: rdata_d[aewr_pkg::EV_NUM-1:0] = ev_status;
				aewr_pkg::OFS_IRQ_EN: rdata_d[aewr_pkg::EV_NUM-1:0] = ev_enable;
				default:              rdata_d = aewr_pkg::RESET_WORD;
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stall_q <= 1'b0;
			s2v_q   <= 1'b0;
			s2m_q   <= 1'b0;
			s3v_q   <= 1'b0;
			frame_q <= aewr_pkg::RESET_WORD;
			fa_q    <= aewr_pkg::RESET_WORD;
			ack_q   <= 1'b0;
			rdata_q <= aewr_pkg::RESET_WORD;
		end else begin
			stall_q <= stall_d;
			s2v_q   <= s2v_d;
			s2m_q   <= s2m_d;
			s3v_q   <= s3v_d;
			frame_q <= frame_d;
			fa_q    <= fa_d;
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	aewr_events #(
		.N (aewr_pkg::EV_NUM)
	) u_events (
		.clock       (clock),
		.rst         (rst),
		.event_set   (ev_set),
		.clear_bits  (wb_dat_i[aewr_pkg::EV_NUM-1:0]),
		.clear_we    (clr_we),
		.enable_bits (wb_dat_i[aewr_pkg::EV_NUM-1:0]),
		.enable_we   (en_we),
		.status      (ev_status),
		.enable      (ev_enable),
		.irq         (irq)
	);

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	read_wb12_a: assert property (take_fault && fault_kind == aewr_pkg::AEWR_READ |=>
		!frame_q[aewr_pkg::FB_WB1_V] && !frame_q[aewr_pkg::FB_WB2_V] && frame_q[aewr_pkg::FB_RW])
		else $error("read fault reported a first or second write-back");
	stall_hold_a: assert property ((rd_start || dm_stall) && !rd_data_done |=> dm_stall)
		else $error("data stage released before read data returned");
	stall_end_a: assert property (rd_data_done && !rd_start |=> !dm_stall)
		else $error("data stage still stalled after read data returned");
	read_wb3_a: assert property (take_fault && fault_kind == aewr_pkg::AEWR_READ |=>
		frame_q[aewr_pkg::FB_WB3_V] == $past(s3v_q))
		else $error("third write-back lost on read fault");
	push_wb1_a: assert property (take_fault && fault_kind == aewr_pkg::AEWR_PUSH |=>
		frame_q[aewr_pkg::FB_VALID] && !frame_q[aewr_pkg::FB_WB1_V])
		else $error("push fault reported first write-back valid");
	fault_addr_a: assert property (take_fault |=> fa_q == (($past(fault_kind) == aewr_pkg::AEWR_PUSH) ?
		$past(fault_physical_addr) : $past(fault_logical_addr)))
		else $error("fault address from the wrong source");
	lm_excl_a: assert property (!(s2v_q && s2m_q && s3v_q) &&
		!(frame_q[aewr_pkg::FB_WB2_M] && frame_q[aewr_pkg::FB_WB3_V]))
		else $error("line-move in second slot alongside third write-back");
	lm_hit_a: assert property (slot2_load && slot2_line_move && !slot2_read_hit && !s2v_q |=> !s2v_q)
		else $error("line-move accepted without a cache hit");
	push_code_a: assert property (take_fault && fault_kind == aewr_pkg::AEWR_PUSH |=>
		frame_q[aewr_pkg::FB_TT_LO +: 2] == aewr_pkg::TT_NORMAL &&
		frame_q[aewr_pkg::FB_TM_LO +: 3] == aewr_pkg::TM_PUSH)
		else $error("push fault with wrong transfer codes");

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus acknowledge held longer than one cycle");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged in the next cycle");
	rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == aewr_pkg::RESET_WORD)
		else $error("read data shown outside an acknowledge");
	irq_level_a: assert property (irq == |(ev_status & ev_enable))
		else $error("interrupt level does not follow enabled status");

	frame_hold_a: assert property (frame_valid && !release_we |=> frame_valid)
		else $error("frame dropped without a release");
	frame_free_a: assert property (release_we && frame_valid |=> !frame_valid)
		else $error("frame still held after a release");
	capture_flag_a: assert property (take_fault |=> frame_valid && ev_status[aewr_pkg::EV_CAPTURE])
		else $error("capture not flagged");
	overrun_flag_a: assert property (fault_valid && frame_valid |=> ev_status[aewr_pkg::EV_OVERRUN])
		else $error("refused fault not flagged as overrun");
	slots_empty_a: assert property (take_fault |=> !s2v_q && !s2m_q && !s3v_q)
		else $error("pending slots kept after capture");
	stall_start_a: assert property (rd_start && !rd_data_done |=> dm_stall)
		else $error("data stage not stalled after a read started");

	write_wb1_a: assert property (take_fault && (fault_kind == aewr_pkg::AEWR_WRITE ||
		fault_kind == aewr_pkg::AEWR_LM_WRITE) |=> frame_q[aewr_pkg::FB_WB1_V] && !frame_q[aewr_pkg::FB_RW])
		else $error("write fault without a valid first write-back");
	lm_code_a: assert property (take_fault && fault_kind == aewr_pkg::AEWR_LM_WRITE |=>
		frame_q[aewr_pkg::FB_WB1_M] && frame_q[aewr_pkg::FB_TT_LO +: 2] == aewr_pkg::TT_LINE_MOVE)
		else $error("line-move write fault with wrong marking");
	page_wb1_a: assert property (take_fault && fault_kind == aewr_pkg::AEWR_PAGE_FAULT |=>
		!frame_q[aewr_pkg::FB_WB1_V] && !frame_q[aewr_pkg::FB_RW])
		else $error("page fault reported a first write-back");
	frame_wb2_a: assert property (take_fault && fault_kind != aewr_pkg::AEWR_READ |=>
		frame_q[aewr_pkg::FB_WB2_V] == $past(s2v_q) && frame_q[aewr_pkg::FB_WB2_M] == ($past(s2v_q) && $past(s2m_q)))
		else $error("second write-back not carried into the frame");
	lm_slot3_a: assert property (slot2_line_move && s3v_q |-> !slot2_ready)
		else $error("line-move could enter the second slot beside a third write-back");
	post_lm_a: assert property (s2v_q && s2m_q |-> !exec_post_ready)
		else $error("write posted while a line-move holds the second slot");
	post_full_a: assert property (s3v_q |-> !exec_post_ready)
		else $error("write posted into a full third slot");

	push_lm_c: cover property (take_fault && fault_kind == aewr_pkg::AEWR_PUSH && s2v_q && s2m_q);
	read_wb3_c: cover property (take_fault && fault_kind == aewr_pkg::AEWR_READ && s3v_q);
	page_fault_c: cover property (take_fault && fault_kind == aewr_pkg::AEWR_PAGE_FAULT && s2v_q);
	lm_slot2_c: cover property (s2v_q && s2m_q && !s3v_q);
	overrun_c: cover property (fault_valid && frame_valid);
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
	logic        clock, rst, cyc, stb, we, ack, irq;
	logic        rs, rdd, stall, l2, lm, hit, r2, d2, pq, pr, d3, fv, fvo;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [2:0]  fk, ftm;
	logic [31:0] wdat, rdat, fla, fpa, q, e, hx;
	int          fails, samples_checked;

	aewr_core aewr_core_i (
		.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq),
		.rd_start(rs), .rd_data_done(rdd), .dm_stall(stall), .slot2_load(l2), .slot2_line_move(lm),
		.slot2_read_hit(hit), .slot2_ready(r2), .slot2_drain(d2), .exec_post_req(pq),
		.exec_post_ready(pr), .slot3_drain(d3), .fault_valid(fv), .fault_kind(fk), .fault_tm(ftm),
		.fault_logical_addr(fla), .fault_physical_addr(fpa), .frame_valid(fvo)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic report_and_stop;
		if (fails == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			fails++;
			$display("ERROR %s expected %h seen %h", s, x, g);
		end
	endtask

	task automatic c1(input string s, input logic g, input logic x);
		chk(s, {31'h0, g}, {31'h0, x});
	endtask

	// classic single cycle: hold until ack is sampled, then release for one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// ack is looked at half a cycle before each rising edge: the value that edge samples
		do begin
			@(negedge clock);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		c1("ack", ack, 1'b1);
		@(posedge clock);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
		wb(1'b0, a, 32'h0);
		chk(s, q, x);
	endtask

	task automatic pulse_fault;
		fv <= 1'b1;
		@(posedge clock);
		fv <= 1'b0;
		@(posedge clock);
	endtask

	initial begin
		#50us;
		fails++;
		report_and_stop;
	end

	initial begin
		{cyc, stb, we, rs, rdd, l2, lm, hit, d2, pq, d3, fv} = '0;
		adr = 8'h00;
		sel = 4'hf;
		wdat = 32'h0;
		fk = 3'h0;
		ftm = 3'h0;
		fla = 32'h0;
		fpa = 32'h0;
		rst = 1'b1;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rd(aewr_pkg::OFS_IRQ_ST, 32'h0, "irq_status");
		rd(aewr_pkg::OFS_FRAME, aewr_pkg::RESET_WORD, "frame");
		rd(8'h40, 32'h0, "unmapped");
		rd(aewr_pkg::OFS_IRQ_CLR, 32'h0, "irq_clear");
		// stall holds across a multi-cycle read until data comes back
		rs <= 1'b1;
		@(posedge clock);
		rs <= 1'b0;
		repeat (3) @(posedge clock);
		c1("dm_stall", stall, 1'b1);
		rdd <= 1'b1;
		@(posedge clock);
		rdd <= 1'b0;
		@(posedge clock);
		c1("dm_stall", stall, 1'b0);
		lm <= 1'b1;
		hit <= 1'b0;
		@(posedge clock);
		c1("slot2_ready", r2, 1'b0);
		hit <= 1'b1;
		@(posedge clock);
		c1("slot2_ready", r2, 1'b1);
		// fill both slots, then drain them one at a time
		lm <= 1'b0;
		l2 <= 1'b1;
		pq <= 1'b1;
		@(posedge clock);
		l2 <= 1'b0;
		pq <= 1'b0;
		@(posedge clock);
		c1("slot2_ready_full", r2, 1'b0);
		c1("exec_post_ready_full", pr, 1'b0);
		d2 <= 1'b1;
		@(posedge clock);
		d2 <= 1'b0;
		lm <= 1'b1;
		@(posedge clock);
		c1("slot2_ready_lm", r2, 1'b0);
		d3 <= 1'b1;
		@(posedge clock);
		d3 <= 1'b0;
		lm <= 1'b0;
		@(posedge clock);
		c1("slot2_ready_drained", r2, 1'b1);
		c1("exec_post_ready_drained", pr, 1'b1);
		for (int k = 0; k < 5; k++) begin
			lm <= (k == 1 || k == 4);
			l2 <= 1'b1;
			pq <= 1'b1;
			@(negedge clock);
			c1("exec_post_ready", pr, k != 1 && k != 4);
			@(posedge clock);
			l2 <= 1'b0;
			pq <= 1'b0;
			@(posedge clock);
			c1("exec_post_held", pr, 1'b0);
			fk <= k[2:0];
			ftm <= 3'h5;
			fla <= 32'h1000_0000 + k;
			fpa <= 32'h2000_0040 + k;
			pulse_fault();
			c1("frame_valid", fvo, 1'b1);
			e = 32'h0001_0000;
			e[0] = (k == 2 || k == 3);
			e[1] = (k == 3);
			e[2] = (k != 0);
			e[3] = (k == 1 || k == 4);
			e[4] = (k != 1 && k != 4);
			e[6] = (k == 0);
			e[8] = (k == 3);
			e[12:10] = (k == 1) ? 3'h0 : 3'h5;
			rd(aewr_pkg::OFS_FRAME, e, "frame");
			// the bench acts as handler: slots are visited first, second, third
			hx = (k == 0) ? 32'h4 : (k == 2) ? 32'h7 : (k == 3) ? 32'h6 : 32'h0;
			chk("handler_writes", {29'h0, q[4], q[2] && !q[3], q[0] && !q[1]}, hx);
			c1("hard_cleanup", q[3] && !q[0] && !q[6] && q[12:10] != 3'h0, k == 4);
			rd(aewr_pkg::OFS_FADDR, (k == 1) ? fpa : fla, "fault_addr");
			if (k == 0) begin
				c1("irq_masked", irq, 1'b0);
				wb(1'b1, aewr_pkg::OFS_IRQ_EN, 32'h3);
			end
			c1("irq", irq, 1'b1);
			// a second fault while the frame is held is refused and flagged
			pulse_fault();
			rd(aewr_pkg::OFS_FADDR, (k == 1) ? fpa : fla, "fault_addr_held");
			rd(aewr_pkg::OFS_IRQ_ST, 32'h3, "irq_status");
			wb(1'b1, aewr_pkg::OFS_IRQ_CLR, 32'h3);
			rd(aewr_pkg::OFS_IRQ_ST, 32'h0, "irq_status_cleared");
			c1("irq_cleared", irq, 1'b0);
			wb(1'b1, aewr_pkg::OFS_CTRL, 32'h1);
			c1("frame_released", fvo, 1'b0);
		end
		report_and_stop;
	end
endmodule
